// [rtl/tpwm_map.svh]
// Constants for the timer channel pulse-width modulation mode.
`ifndef TPWM_MAP_SVH
`define TPWM_MAP_SVH
`define TPWM_MODE_PWM      2'b11
`define TPWM_SRC_UNDIV     2'b00
`define TPWM_SRC_DIV8      2'b01
`define TPWM_SRC_PROG      2'b10
`define TPWM_SRC_SUB       2'b11
`define TPWM_TRG_SOFT      2'b00
`define TPWM_TRG_PIN       2'b01
`define TPWM_TRG_TIMER     2'b10
`define TPWM_DIV8_LAST     3'h7
`define TPWM_PERIOD16      17'h0ffff
`define TPWM_PERIOD8       9'h0ff
`define TPWM_RESET_WIDTH   16'h0000
`endif

// [rtl/tpwm_pkg.sv]
// Types for the timer channel pulse-width modulation mode.
package tpwm_pkg;
    typedef enum logic [1:0] {
        TPWM_IDLE,
        TPWM_ARMED,
        TPWM_RUN
    } tpwm_state_e;

    typedef struct packed {
        tpwm_state_e state;
        logic [15:0] reload;
        logic [15:0] width_cnt;
        logic [15:0] phase_cnt;
        logic [7:0]  pre_cnt;
        logic [2:0]  div8_cnt;
        logic        pulse;
        logic        irq;
        logic [1:0]  trg_sync;
        logic        trg_prev;
        logic [1:0]  sub_sync;
        logic        sub_prev;
    } tpwm_state_s;
endpackage

// [rtl/tpwm_channel.sv]
// Timer channel in pulse-width modulation mode, with count source select and start triggers.
`timescale 1ns/1ps
`default_nettype none
`include "tpwm_map.svh"

module tpwm_channel
    import tpwm_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        resetn,
    input  wire logic        op_mode_select_low,
    input  wire logic        op_mode_select_high,
    input  wire logic [1:0]  count_source_sel,
    input  wire logic        prog_div_tick,
    input  wire logic        subclock_derived_source,
    input  wire logic        eight_bit_mode,
    input  wire logic [1:0]  trigger_sel,
    input  wire logic        trigger_rising,
    input  wire logic        channel_run_bit,
    input  wire logic        channel_width_wr,
    input  wire logic [15:0] channel_width_wdata,
    output logic      [15:0] channel_width_rdata,
    input  wire logic        channel_trigger_pin,
    input  wire logic        timer_b2_flow,
    input  wire logic        timer_below_flow,
    input  wire logic        timer_above_flow,
    output logic             channel_pulse_pin,
    output logic             channel_irq,
    output logic             channel_running
);

    tpwm_state_s s_q;
    tpwm_state_s s_d;

    logic        pwm_mode;
    logic        tick;
    logic        start_evt;
    logic        trg_edge;
    logic        step;
    logic [7:0]  pre_len;

    // Remaining high cycles for a width value, in count-source units or prescaled units.
    function automatic logic [15:0] high_len(input logic eight, input logic [15:0] w);
        high_len = eight ? {8'h00, w[15:8]} : w;
    endfunction

    // Remaining period length in count-source units or prescaled units.
    function automatic logic [15:0] period_len(input logic eight);
        period_len = eight ? {8'h00, 8'(`TPWM_PERIOD8)} : 16'(`TPWM_PERIOD16);
    endfunction

    // Mode decode: only the divide-by-eight counter runs unless the mode field selects modulation.
    assign pwm_mode = ({op_mode_select_high, op_mode_select_low} == `TPWM_MODE_PWM);

    // Count source tick; the subclock input crosses domains so it is synchronised first.
    always_comb begin
        case (count_source_sel)
            `TPWM_SRC_UNDIV: tick = 1'b1;
            `TPWM_SRC_DIV8:  tick = (s_q.div8_cnt == `TPWM_DIV8_LAST);
            `TPWM_SRC_PROG:  tick = prog_div_tick;
            `TPWM_SRC_SUB:   tick = s_q.sub_sync[1] & ~s_q.sub_prev;
            default:         tick = 1'b0;
        endcase
    end

    // Trigger pin edge after two-flop synchronisation; edge polarity is configurable.
    assign trg_edge = trigger_rising ? (s_q.trg_sync[1] & ~s_q.trg_prev)
                                     : (~s_q.trg_sync[1] & s_q.trg_prev);

    // Start event for the selected source; any trigger while running is ignored later.
    always_comb begin
        case (trigger_sel)
            `TPWM_TRG_SOFT:  start_evt = 1'b1;
            `TPWM_TRG_PIN:   start_evt = trg_edge;
            `TPWM_TRG_TIMER: start_evt = timer_b2_flow | timer_below_flow
                                         | timer_above_flow;
            default:         start_evt = 1'b0;
        endcase
    end

    // The prescaler in 8-bit mode divides the tick by m+1.
    assign pre_len = eight_bit_mode ? s_q.reload[7:0] : 8'h00;
    assign step    = tick & (s_q.pre_cnt == 8'h00);

    // Next state of the whole channel.
    always_comb begin
        s_d          = s_q;
        s_d.irq      = 1'b0;
        s_d.trg_sync = {s_q.trg_sync[0], channel_trigger_pin};
        s_d.trg_prev = s_q.trg_sync[1];
        s_d.sub_sync = {s_q.sub_sync[0], subclock_derived_source};
        s_d.sub_prev = s_q.sub_sync[1];
        s_d.div8_cnt = 3'(s_q.div8_cnt + 3'h1);
        // Width writes: the counter takes the value too unless counting is under way.
        if (channel_width_wr) begin
            s_d.reload = channel_width_wdata;
            if (s_q.state != TPWM_RUN) begin
                s_d.width_cnt = channel_width_wdata;
            end
        end
        case (s_q.state)
            TPWM_IDLE: begin
                s_d.pulse = 1'b0;
                if (pwm_mode && channel_run_bit) begin
                    s_d.state = TPWM_ARMED;
                end
            end
            TPWM_ARMED: begin
                if (!pwm_mode || !channel_run_bit) begin
                    s_d.state = TPWM_IDLE;
                end else if (start_evt) begin
                    s_d.state = TPWM_RUN;
                    s_d.pre_cnt = pre_len;
                    s_d.phase_cnt = period_len(eight_bit_mode);
                    s_d.width_cnt = high_len(eight_bit_mode,
                                             channel_width_wr ? channel_width_wdata
                                                              : s_q.width_cnt);
                    s_d.pulse = (high_len(eight_bit_mode, channel_width_wr
                                 ? channel_width_wdata : s_q.width_cnt) != 16'h0000);
                end
            end
            TPWM_RUN: begin
                if (!pwm_mode || !channel_run_bit) begin
                    s_d.state = TPWM_IDLE;
                    s_d.pulse = 1'b0;
                end else if (tick) begin
                    s_d.pre_cnt = (s_q.pre_cnt == 8'h00) ? pre_len : 8'(s_q.pre_cnt - 8'h01);
                    if (step) begin
                        s_d.phase_cnt = 16'(s_q.phase_cnt - 16'h0001);
                        if (s_q.width_cnt != 16'h0000) begin
                            s_d.width_cnt = 16'(s_q.width_cnt - 16'h0001);
                        end
                        if (s_q.width_cnt == 16'h0001 && s_q.pulse) begin
                            s_d.pulse = 1'b0;
                            s_d.irq   = 1'b1;
                        end
                        if (s_q.phase_cnt == 16'h0001) begin
                            // Period end: reload, and raise the output again if the reloaded width is not zero.
                            s_d.phase_cnt = period_len(eight_bit_mode);
                            s_d.width_cnt = high_len(eight_bit_mode, s_q.reload);
                            s_d.pulse = (high_len(eight_bit_mode, s_q.reload) != 16'h0000);
                            if (s_q.pulse && s_q.width_cnt == 16'h0001 &&
                                high_len(eight_bit_mode, s_q.reload) != 16'h0000) begin
                                s_d.irq = 1'b1;
                            end
                        end
                    end
                end
            end
            default: s_d.state = TPWM_IDLE;
        endcase
    end

    // State register; async reset gives constants only.
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            s_q <= '{state: TPWM_IDLE, reload: `TPWM_RESET_WIDTH,
                     width_cnt: `TPWM_RESET_WIDTH, default: '0};
        end else begin
            s_q <= s_d;
        end
    end

    // Reads give no defined count; zero is returned so nothing depends on it.
    assign channel_width_rdata = 16'h0000;
    assign channel_pulse_pin   = s_q.pulse;
    assign channel_irq         = s_q.irq;
    assign channel_running     = (s_q.state == TPWM_RUN);

    // All checks below run on the channel clock and are idle while reset is applied.
    // Counting antecedents also ask for the run bit and the mode field, because a stop
    // or a mode change on the same edge overrides any counting step.
    // They watch internal state, so a broken counter is caught before the pin shows it.

    // Output stays low whenever the channel is not counting.
    a_low_stopped: assert property (@(posedge clk) disable iff (!resetn)
        (s_q.state != TPWM_RUN) |=>
        !channel_pulse_pin || $past(s_q.state) == TPWM_ARMED)
        else $error("pulse high while stopped");

    // An interrupt pulse only ever follows an edge on which the output was high.
    a_irq_fall: assert property (@(posedge clk) disable iff (!resetn)
        channel_irq |->
        $past(s_q.pulse))
        else $error("interrupt without preceding high output");

    // Clearing the run bit ends counting on the very next edge.
    a_stop_run: assert property (@(posedge clk) disable iff (!resetn)
        (!channel_run_bit && s_q.state == TPWM_RUN) |=>
        !channel_running)
        else $error("run bit clear did not stop");

    // Between ticks nothing moves the counters; a start trigger here has no effect.
    // Writes while running go to the reload register only, so they are not excused.
    a_no_retrig: assert property (@(posedge clk) disable iff (!resetn)
        (channel_running && channel_run_bit && pwm_mode && !tick) |=>
        $stable(s_q.width_cnt) && $stable(s_q.phase_cnt) && $stable(s_q.pre_cnt))
        else $error("counter moved without tick");

    // Any mode other than modulation keeps the channel out of the counting state.
    a_mode_gate: assert property (@(posedge clk) disable iff (!resetn)
        !pwm_mode |=>
        !channel_running)
        else $error("counting outside modulation mode");

    // A write while running still reaches the reload register.
    a_write_run: assert property (@(posedge clk) disable iff (!resetn)
        (channel_width_wr && channel_running && !tick) |=>
        s_q.reload == $past(channel_width_wdata))
        else $error("reload not updated by write");

    // A write while stopped loads the counter as well.
    a_write_stop: assert property (@(posedge clk) disable iff (!resetn)
        (channel_width_wr && s_q.state == TPWM_IDLE) |=>
        s_q.width_cnt == $past(channel_width_wdata))
        else $error("stopped write did not load counter");

    // With software start selected, an armed channel starts on the next edge.
    a_soft_start: assert property (@(posedge clk) disable iff (!resetn)
        (s_q.state == TPWM_ARMED && channel_run_bit && pwm_mode &&
         trigger_sel == `TPWM_TRG_SOFT) |=> channel_running)
        else $error("software start not taken");

    // The read port is a fixed value; software must not depend on it anyway.
    a_read_zero: assert property (@(posedge clk) disable iff (!resetn)
        channel_width_rdata == 16'h0000)
        else $error("read value not constant");

    // A rise inside the counting state is a reload: the counter takes the reload value.
    // The width is taken in the units of the mode in force on that edge.
    a_rise_reload: assert property (@(posedge clk) disable iff (!resetn)
        ($rose(channel_pulse_pin) && $past(s_q.state) == TPWM_RUN) |->
        s_q.width_cnt == high_len($past(eight_bit_mode), $past(s_q.reload)))
        else $error("counter not reloaded at output rise");

    // Every reload restarts the fixed period, whatever the width.
    a_period_load: assert property (@(posedge clk) disable iff (!resetn)
        ($rose(channel_pulse_pin) && $past(s_q.state) == TPWM_RUN) |->
        s_q.phase_cnt == period_len($past(eight_bit_mode)))
        else $error("period not restarted at output rise");

    // Each counting step restarts the prescaler from the lower byte in 8-bit mode.
    a_pre_reload: assert property (@(posedge clk) disable iff (!resetn)
        (channel_running && channel_run_bit && pwm_mode && step) |=>
        s_q.pre_cnt == $past(pre_len))
        else $error("prescaler not restarted");

    // A fall that keeps the channel running always carries an interrupt request.
    a_fall_irq: assert property (@(posedge clk) disable iff (!resetn)
        ($fell(channel_pulse_pin) && channel_running) |->
        channel_irq)
        else $error("output fall without interrupt");

    // The high-time counter goes down by one on each step until it reaches zero.
    a_width_step: assert property (@(posedge clk) disable iff (!resetn)
        (channel_running && channel_run_bit && pwm_mode && step &&
         s_q.phase_cnt != 16'h0001 && s_q.width_cnt != 16'h0000) |=>
        s_q.width_cnt == 16'($past(s_q.width_cnt) - 16'h0001))
        else $error("width counter did not step down");

    // The period counter counts downward on each step between reloads.
    a_phase_step: assert property (@(posedge clk) disable iff (!resetn)
        (channel_running && channel_run_bit && pwm_mode && step &&
         s_q.phase_cnt != 16'h0001) |=>
        s_q.phase_cnt == 16'($past(s_q.phase_cnt) - 16'h0001))
        else $error("period counter did not step down");

    // A synchronised pin edge starts an armed channel when the pin is the trigger.
    a_trig_start: assert property (@(posedge clk) disable iff (!resetn)
        (s_q.state == TPWM_ARMED && channel_run_bit && pwm_mode &&
         trigger_sel == `TPWM_TRG_PIN && trg_edge) |=> channel_running)
        else $error("pin trigger start not taken");

    // Any neighbour flow pulse starts an armed channel when timers are the trigger.
    a_timer_start: assert property (@(posedge clk) disable iff (!resetn)
        (s_q.state == TPWM_ARMED && channel_run_bit && pwm_mode &&
         trigger_sel == `TPWM_TRG_TIMER &&
         (timer_b2_flow || timer_below_flow || timer_above_flow)) |=> channel_running)
        else $error("timer trigger start not taken");

    // The stopped state always shows a low output.
    a_idle_low: assert property (@(posedge clk) disable iff (!resetn)
        (s_q.state == TPWM_IDLE) |->
        !channel_pulse_pin)
        else $error("pulse high while idle");

    // The unused trigger select code never starts the channel.
    a_sel_never: assert property (@(posedge clk) disable iff (!resetn)
        (s_q.state == TPWM_ARMED && trigger_sel == 2'b11) |=>
        !channel_running)
        else $error("reserved trigger select started the channel");

    // The divide-by-eight source never ticks on two edges in a row.
    a_div8_tick: assert property (@(posedge clk) disable iff (!resetn)
        (count_source_sel == `TPWM_SRC_DIV8 && tick) |=>
        (!tick || count_source_sel != `TPWM_SRC_DIV8))
        else $error("divided source ticked twice in a row");

    // Channel reaches the counting state.
    c_run: cover property (@(posedge clk) disable iff (!resetn)
        $rose(channel_running));

    // An interrupt request is raised.
    c_irq: cover property (@(posedge clk) disable iff (!resetn)
        channel_irq);

    // A pulse starts in 8-bit mode.
    c_eight: cover property (@(posedge clk) disable iff (!resetn)
        eight_bit_mode && $rose(channel_pulse_pin));

    // A start through the trigger pin.
    c_pin_start: cover property (@(posedge clk) disable iff (!resetn)
        $rose(channel_running) && trigger_sel == `TPWM_TRG_PIN);

    // A start through a neighbouring timer.
    c_timer_start: cover property (@(posedge clk) disable iff (!resetn)
        $rose(channel_running) && trigger_sel == `TPWM_TRG_TIMER);

endmodule // tpwm_channel
`default_nettype wire

// [test/tpwm_load.sv]
// External load on the pulse pin that measures high time and period in clock cycles.
`timescale 1ns/1ps
`default_nettype none
module tpwm_load (
    input  wire logic clk,
    input  wire logic pin,
    output int        hi_len,
    output int        per_len,
    output int        rises,
    output int        falls
);
    int   cnt = 0;
    logic prev = 1'b0;
    // A load sees only the pin level, so lengths are counted in sampled clock edges.
    always @(posedge clk) begin
        prev <= pin;
        cnt <= (pin && !prev) ? 1 : cnt + 1;
        if (pin && !prev) begin
            per_len <= cnt;
            rises <= rises + 1;
        end
        if (!pin && prev) begin
            hi_len <= cnt;
            falls <= falls + 1;
        end
    end
endmodule // tpwm_load
`default_nettype wire

// [test/test_timer_pwm_mode.sv]
// Self-checking bench for the pulse-width modulation timer channel.
`timescale 1ns/1ps
`default_nettype none
module test_timer_pwm_mode;
    import tpwm_pkg::*;
    logic        clk = 1'b0, resetn = 1'b0, mode_lo = 1'b1, eight = 1'b0, run = 1'b0;
    logic        wr = 1'b0, tpin = 1'b0, pin, irq, running;
    logic [1:0]  src = 2'b00, trg = 2'b00;
    logic [2:0]  flows = 3'h0;
    logic [15:0] wdata = 16'h0000, rdata;
    logic [7:0]  m, n1, n2;
    int          ph = 0, hi_len, per_len, rises, falls, irq_cnt, err_count, total_checks;
    int          divs[4] = '{1, 8, 3, 8};
    tpwm_channel DUT (.clk(clk), .resetn(resetn), .op_mode_select_low(mode_lo),
        .op_mode_select_high(1'b1), .count_source_sel(src), .prog_div_tick(ph % 3 == 2),
        .subclock_derived_source(ph[2]), .eight_bit_mode(eight), .trigger_sel(trg),
        .trigger_rising(1'b1), .channel_run_bit(run), .channel_width_wr(wr),
        .channel_width_wdata(wdata), .channel_width_rdata(rdata), .channel_trigger_pin(tpin),
        .timer_b2_flow(flows[0]), .timer_below_flow(flows[1]), .timer_above_flow(flows[2]),
        .channel_pulse_pin(pin), .channel_irq(irq), .channel_running(running));
    tpwm_load load (.clk(clk), .pin(pin), .hi_len(hi_len), .per_len(per_len),
        .rises(rises), .falls(falls));
    // Clock, and the slow count sources: a tick every third cycle, a subclock of eight.
    initial begin
        forever #20 clk = ~clk;
    end
    always @(negedge clk) begin
        ph <= ph + 1;
    end
    // Interrupt pulses are tallied so they can be matched against output falls.
    always @(posedge clk) begin
        if (irq === 1'b1) begin
            irq_cnt++;
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic finish_test();
        $display("Checks %0d, mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // Starts the channel through whichever trigger is selected; soft start needs nothing.
    task automatic fire();
        if (trg == 2'b01) begin
            tpin = 1'b1;
            repeat (3) @(negedge clk);
            tpin = 1'b0;
        end else if (trg == 2'b10) begin
            flows = 3'b001 << ($urandom % 3);
            @(negedge clk);
            flows = 3'h0;
        end
    endtask
    // A bounded wait of at most 70000 cycles, so a dead output cannot stall any one wait forever.
    task automatic wait_pin(input int r, input int f);
        int guard;
        guard = 0;
        while ((rises < r || falls < f) && guard < 70000) begin
            @(negedge clk);
            guard++;
        end
    endtask
    task automatic write_width(input logic [15:0] w);
        wdata = w;
        wr = 1'b1;
        @(negedge clk);
        wr = 1'b0;
    endtask
    // The width is changed after the first rise, so the second high shows the new value.
    task automatic run_case(input logic [1:0] s, input logic e, input logic [15:0] w,
                            input logic [15:0] w2);
        int r0, f0, i0, hi, per;
        src = s;
        trg = 2'(s % 3);
        eight = e;
        write_width(w);
        run = 1'b1;
        r0 = rises;
        f0 = falls;
        i0 = irq_cnt;
        repeat (3) @(negedge clk);
        fire();
        wait_pin(r0 + 1, f0);
        write_width(w2);
        fire();
        // The start rise is not tick aligned for slow sources, so 8-bit waits a third rise.
        wait_pin(r0 + 2 + int'(e), f0 + 2);
        repeat (3) @(negedge clk);
        hi = e ? w2[15:8] * (w2[7:0] + 1) * divs[s] : w2 * divs[s];
        per = e ? 255 * (w[7:0] + 1) * divs[s] : 65535 * divs[s];
        check(hi_len, hi);
        check(per_len, per);
        check(irq_cnt - i0, falls - f0);
        run = 1'b0;
        repeat (4) @(negedge clk);
        check({pin, running}, 2'b00);
        check(rdata, 16'h0000);
    endtask
    // Main sequence: a refused start, one 16-bit case, then each count source in 8-bit.
    initial begin
        void'($urandom(32'hf8046391));
        repeat (2) @(negedge clk);
        resetn = 1'b1;
        mode_lo = 1'b0;
        run = 1'b1;
        repeat (5) @(negedge clk);
        check({pin, running}, 2'b00);
        run = 1'b0;
        mode_lo = 1'b1;
        @(negedge clk);
        n1 = 8'(1 + $urandom % 200);
        run_case(2'b00, 1'b0, {8'h00, n1}, {8'h00, n1} + 16'h0003);
        for (int s = 0; s < 4; s++) begin
            m = 8'($urandom % 2);
            n1 = 8'(1 + $urandom % 254);
            n2 = 8'(1 + $urandom % 254);
            run_case(2'(s), 1'b1, {n1, m}, {n2, m});
        end
        finish_test();
    end
    // A hang is cut off well past the longest expected run.
    initial begin
        #(120000 * 40);
        err_count++;
        finish_test();
    end
endmodule // test_timer_pwm_mode
`default_nettype wire
